// File: sdp_ram.sv
// Purpose: Small embedded simple dual-port RAM with FIFO, ROM and shift modes
// Assumes: edge_a and edge_b mark active edges of the two block clocks
// Notes: Contents preload from INIT_IMAGE at reset; registers on a plain port
`timescale 1ns/10ps
// Operation
// - 576 bits, 32 words of 18 bits
// - One write and one read port, concurrent
// - Modes SDP, single-port, FIFO, ROM, shift
// - RAM or ROM contents preload from image
// - Write-side registers share one selected clock
// - Read and output registers pick either clock
// - Only output register may be bypassed
// - Input clear immediate, read word and output left as they are
// - Output clear takes effect immediately unless the output register is bypassed
// - Write, read, clock enable, clears from fabric
// - Parity bits stored or dropped per option
module sdp_ram import sdp_ram_pkg::*; #(
	parameter logic [TOTAL_BITS-1:0] INIT_IMAGE = '0
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic edge_a,
	input wire logic edge_b,
	input wire logic ce,
	input wire logic aclr_in,
	input wire logic aclr_out,
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [WORD_W-1:0] din,
	input wire logic re,
	input wire logic [ADDR_W-1:0] raddr,
	output logic [WORD_W-1:0] q,
	output logic fifo_full,
	output logic fifo_empty,
	input wire logic [BUS_AW-1:0] bus_addr,
	input wire logic [BUS_DW-1:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	output logic [BUS_DW-1:0] bus_rdata
);
	logic [WORD_W-1:0] mem [DEPTH]; // Storage array
	logic [CFG_W-1:0] cfg_r; // Configuration register
	logic [BUS_DW-1:0] rdata_r; // Bus read data
	logic we_r; // Write enable input register
	logic [ADDR_W-1:0] waddr_r; // Write address input register
	logic [WORD_W-1:0] din_r; // Write data input register
	logic rd_en_r; // Read enable input register
	logic [ADDR_W-1:0] rd_addr_r; // Read address input register
	logic [WORD_W-1:0] rd_raw_r; // Word read from the array
	logic [ADDR_W-1:0] wptr_r; // FIFO write and shift pointer
	logic [ADDR_W-1:0] rptr_r; // FIFO read pointer
	logic [CNT_W-1:0] count_r; // FIFO occupancy
	logic [CNT_W-1:0] count_nxt;
	mode_e mode;

	// Configuration decode
	wire [2:0] mode_code = cfg_r[CFG_MODE_LSB +: 3];
	wire wr_sel = cfg_r[CFG_WRSEL_BIT];
	wire rd_sel = cfg_r[CFG_RDSEL_BIT];
	wire out_sel = cfg_r[CFG_OUTSEL_BIT];
	wire bypass = cfg_r[CFG_BYP_BIT];
	wire par_en = cfg_r[CFG_PAR_BIT];
	wire [ADDR_W-1:0] taps = cfg_r[CFG_TAPS_LSB +: ADDR_W];

	// Unused codes fall back to simple dual-port
	always_comb begin
		unique case (mode_code)
			3'h1: mode = MODE_SP;
			3'h2: mode = MODE_FIFO;
			3'h3: mode = MODE_ROM;
			3'h4: mode = MODE_SHIFT;
			default: mode = MODE_SDP;
		endcase
	end

	// Clock selection per register group
	wire wr_tick = (wr_sel ? edge_b : edge_a) & ce;
	wire rd_tick = (rd_sel ? edge_b : edge_a) & ce;
	wire out_tick = out_sel ? edge_b : edge_a;

	// Mode dependent write qualification
	wire is_fifo = (mode == MODE_FIFO);
	wire is_shift = (mode == MODE_SHIFT);
	wire fifo_rd = is_fifo && rd_tick && re && !fifo_empty;
	wire fifo_wr_ok = !is_fifo || !fifo_full || fifo_rd;
	wire mem_we = wr_tick && we && (mode != MODE_ROM) && fifo_wr_ok;
	wire [ADDR_W-1:0] wr_idx = (is_fifo || is_shift) ? wptr_r : waddr;
	wire [WORD_W-1:0] par_mask = par_en ? '1 : WORD_W'(18'h0FFFF);
	wire [WORD_W-1:0] wr_word = din & par_mask;

	// Read address per mode
	wire [ADDR_W-1:0] rd_idx = is_fifo ? rptr_r :
		is_shift ? wptr_r :
		(mode == MODE_SP) ? waddr : raddr;
	wire rd_go = rd_tick && re && (!is_fifo || !fifo_empty);
	wire [WORD_W-1:0] rd_word = mem[rd_idx];

	// Array with preload from the image
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= INIT_IMAGE[i*WORD_W +: WORD_W];
			end
		end else if (mem_we) begin
			mem[wr_idx] <= wr_word;
		end
	end

	// Write side input registers
	wire in_rstn = resetn & ~aclr_in;
	always_ff @(posedge clk or negedge in_rstn) begin
		if (!in_rstn) begin
			we_r <= 1'b0;
			waddr_r <= '0;
			din_r <= '0;
		end else if (wr_tick) begin
			we_r <= we;
			waddr_r <= wr_idx;
			din_r <= wr_word;
		end
	end

	// Read side input registers
	always_ff @(posedge clk or negedge in_rstn) begin
		if (!in_rstn) begin
			rd_en_r <= 1'b0;
			rd_addr_r <= '0;
		end else if (rd_tick) begin
			rd_en_r <= re;
			rd_addr_r <= rd_idx;
		end
	end

	// Raw read word, not touched by the input clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_raw_r <= '0;
		end else if (rd_go) begin
			rd_raw_r <= rd_word;
		end
	end

	// Pointers for FIFO and shift modes
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wptr_r <= '0;
			rptr_r <= '0;
		end else begin
			if (mem_we && is_shift) begin
				wptr_r <= (wptr_r == taps) ? '0 : wptr_r + 1'b1;
			end else if (mem_we && is_fifo) begin
				wptr_r <= wptr_r + 1'b1;
			end
			if (fifo_rd) begin
				rptr_r <= rptr_r + 1'b1;
			end
		end
	end

	// FIFO occupancy
	always_comb begin
		count_nxt = count_r;
		if (is_fifo && mem_we && !fifo_rd) begin
			count_nxt = count_r + 1'b1;
		end else if (fifo_rd && !mem_we) begin
			count_nxt = count_r - 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			count_r <= '0;
		end else begin
			count_r <= count_nxt;
		end
	end

	assign fifo_full = (count_r == CNT_W'(DEPTH));
	assign fifo_empty = (count_r == '0);

	// Output stage with bypass and immediate clear
	sdp_out_stage #(.W(WORD_W)) u_out (
		.clk(clk),
		.resetn(resetn),
		.aclr_out(aclr_out),
		.tick(out_tick),
		.ce(ce),
		.bypass(bypass),
		.d(rd_raw_r),
		.q(q)
	);

	// Register port decode
	wire cfg_hit = (bus_addr == CFG_OFS);
	wire stat_hit = (bus_addr == STAT_OFS);
	wire [BUS_DW-1:0] stat_word = {{(BUS_DW-CNT_W-2){1'b0}}, count_r, fifo_full, fifo_empty};
	wire [BUS_DW-1:0] cfg_word = {{(BUS_DW-CFG_W){1'b0}}, cfg_r};
	wire [BUS_DW-1:0] rd_mux = cfg_hit ? cfg_word : stat_hit ? stat_word : '0;

	// Configuration write
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cfg_r <= CFG_RESET;
		end else if (bus_wr && cfg_hit) begin
			cfg_r <= bus_wdata[CFG_W-1:0];
		end
	end

	// Read data stands one cycle only
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= bus_rd ? rd_mux : '0;
		end
	end

	assign bus_rdata = rdata_r;

	default clocking dflt @(posedge clk); endclocking
	default disable iff (!resetn);

	chk_rom_no_write: assert property ((mode == MODE_ROM) |-> !mem_we)
		else $error("write reached array in read-only mode");
	chk_write_clock: assert property (mem_we |-> (wr_sel ? edge_b : edge_a) && ce && we)
		else $error("write without selected clock edge");
	chk_read_word: assert property ((rd_go && !aclr_in) |=> (rd_raw_r == $past(rd_word)))
		else $error("read word not returned next cycle");
	chk_bypass_read: assert property ((rd_go && bypass && !aclr_out) ##1 bypass |->
		(q == $past(rd_word))) else $error("bypassed read late");
	chk_in_clear: assert property (aclr_in |-> (!we_r && !rd_en_r && rd_addr_r == '0))
		else $error("input registers not cleared");
	chk_clear_holds_out: assert property ((aclr_in && !rd_go) |=> $stable(rd_raw_r))
		else $error("input clear disturbed read word");
	chk_parity_strip: assert property ((mem_we && !par_en) |-> (wr_word[WORD_W-1:PAR_LSB] == '0))
		else $error("parity bits stored while disabled");
	chk_fifo_bound: assert property ((is_fifo && fifo_full && !fifo_rd) |-> !mem_we)
		else $error("write into full buffer");
	chk_read_clock: assert property (rd_go |-> (rd_sel ? edge_b : edge_a))
		else $error("read without selected clock edge");

	cov_fifo_full: cover property (is_fifo && fifo_full);
	cov_shift_wrap: cover property (is_shift && mem_we && wptr_r == taps);
	cov_both_ports: cover property (mem_we && rd_go);
endmodule : sdp_ram

// File: sdp_ram_pkg.sv
// Purpose: Shared constants and types for the small simple dual-port RAM
// Assumes: One system clock; the two block clocks arrive as edge markers
// Notes: Word layout is 16 data bits with 2 parity bits on top
package sdp_ram_pkg;
	localparam int WORD_W = 18; // Widest word, parity included
	localparam int DEPTH = 32; // Words at the widest arrangement
	localparam int TOTAL_BITS = WORD_W * DEPTH; // 576 storage bits
	localparam int ADDR_W = 5; // Word address width
	localparam int DATA_W = 16; // Data bits below the parity bits
	localparam int PAR_LSB = 16; // First parity bit
	localparam int CNT_W = 6; // FIFO occupancy width
	localparam int BUS_AW = 4; // Register port address width
	localparam int BUS_DW = 32; // Register port data width
	// Register offsets
	localparam logic [3:0] CFG_OFS = 4'h0; // Configuration
	localparam logic [3:0] STAT_OFS = 4'h4; // Status
	// Configuration fields
	localparam int CFG_MODE_LSB = 0; // Three-bit mode
	localparam int CFG_WRSEL_BIT = 3; // Write side clock select
	localparam int CFG_RDSEL_BIT = 4; // Read side clock select
	localparam int CFG_OUTSEL_BIT = 5; // Output register clock select
	localparam int CFG_BYP_BIT = 6; // Output register bypass
	localparam int CFG_PAR_BIT = 7; // Parity bits kept
	localparam int CFG_TAPS_LSB = 8; // Shift length minus one
	localparam int CFG_W = 13; // Stored configuration bits
	localparam logic [12:0] CFG_RESET = 13'h1F80; // SDP, clock A, registered, parity, 32 taps
	// Status fields
	localparam int STAT_EMPTY_BIT = 0;
	localparam int STAT_FULL_BIT = 1;
	localparam int STAT_CNT_LSB = 2;
	typedef enum logic [2:0] {
		MODE_SDP,
		MODE_SP,
		MODE_FIFO,
		MODE_ROM,
		MODE_SHIFT
	} mode_e;
endpackage : sdp_ram_pkg

// File: sdp_out_stage.sv
// Purpose: Optional output register with its own clock select and clear
// Assumes: Ticks are one-cycle markers of the chosen block clock edge
// Notes: Clear acts at once on the register, no edge needed
`timescale 1ns/10ps
module sdp_out_stage import sdp_ram_pkg::*; #(
	parameter int W = WORD_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic aclr_out,
	input wire logic tick,
	input wire logic ce,
	input wire logic bypass,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] out_r; // Output register
	wire out_rstn = resetn & ~aclr_out; // Immediate clear path

	// Output register, cleared asynchronously
	always_ff @(posedge clk or negedge out_rstn) begin
		if (!out_rstn) begin
			out_r <= '0;
		end else if (tick && ce) begin
			out_r <= d;
		end
	end

	// Bypass selects the raw read word
	assign q = bypass ? d : out_r;

	chk_out_clear: assert property (@(posedge clk) disable iff (!resetn)
		(aclr_out && !bypass) |-> (q == '0)) else $error("output not cleared at once");
	chk_out_delay: assert property (@(posedge clk) disable iff (!resetn || aclr_out)
		(tick && ce && !bypass) ##1 !bypass |-> (q == $past(d)))
		else $error("output register lost its word");
endmodule : sdp_out_stage

// File: fabric_ticks.sv
// Purpose: Fabric-side model that marks active edges of the two block clocks
// Assumes: Clock A runs at the system rate and clock B at half that rate
// Notes: Markers are one-cycle pulses of the system clock
`timescale 1ns/10ps
module fabric_ticks (
	input wire logic clk,
	input wire logic resetn,
	output logic edge_a,
	output logic edge_b
);
	// Clock B marker alternates, so it fires together with clock A on every other cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			edge_b <= 1'b0;
		end else begin
			edge_b <= ~edge_b;
		end
	end
	// Clock A marker stays quiet in reset, then fires on every cycle
	assign edge_a = resetn;
endmodule : fabric_ticks

// File: tb_small_dual_port_ram.sv
// Purpose: Self-checking bench for the small simple dual-port RAM
// Assumes: Clock A drives every register; ce is held high
// Notes: Word 5 is preloaded so the image and ROM checks can see it
`timescale 1ns/10ps
module tb_small_dual_port_ram import sdp_ram_pkg::*;;
	localparam logic [TOTAL_BITS-1:0] IMG = {{(TOTAL_BITS-108){1'b0}}, 18'h2ABCD, {90{1'b0}}};
	logic clk, resetn, edge_a, edge_b, ce, aclr_in, aclr_out, we, re, bus_wr, bus_rd;
	logic fifo_full, fifo_empty;
	logic [ADDR_W-1:0] waddr, raddr;
	logic [WORD_W-1:0] din, q;
	logic [BUS_AW-1:0] bus_addr;
	logic [BUS_DW-1:0] bus_wdata, bus_rdata, v;
	int failures = 0;
	int compares = 0;
	sdp_ram #(.INIT_IMAGE(IMG)) sdp_ram_i (.clk(clk), .resetn(resetn), .edge_a(edge_a),
		.edge_b(edge_b), .ce(ce), .aclr_in(aclr_in), .aclr_out(aclr_out), .we(we),
		.waddr(waddr), .din(din), .re(re), .raddr(raddr), .q(q), .fifo_full(fifo_full),
		.fifo_empty(fifo_empty), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata));
	fabric_ticks fabric_ticks_i (.clk(clk), .resetn(resetn), .edge_a(edge_a), .edge_b(edge_b));
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Verdict and end of run
	task test_done;
		if (failures == 0 && compares > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : test_done
	// One comparison, counted
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			failures++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Register write, one strobe cycle
	task reg_wr(input logic [3:0] a, input logic [31:0] d);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge clk);
		bus_wr <= 1'b0;
	endtask : reg_wr
	// Register read, data taken at the edge that closes the cycle after the strobe
	task reg_rd(input logic [3:0] a, output logic [31:0] d);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge clk);
		bus_rd <= 1'b0;
		@(posedge clk);
		d = bus_rdata;
	endtask : reg_rd
	// Memory write, inputs set up before the write edge; one idle edge after
	task mem_wr(input logic [4:0] a, input logic [17:0] d);
		we <= 1'b1;
		waddr <= a;
		din <= d;
		@(posedge clk);
		we <= 1'b0;
		@(posedge clk);
	endtask : mem_wr
	// Memory read; registered output lands one edge later
	task mem_rd(input logic [4:0] a, input bit byp, output logic [31:0] d);
		re <= 1'b1;
		raddr <= a;
		@(posedge clk);
		re <= 1'b0;
		@(posedge clk);
		if (!byp) @(posedge clk);
		d = {14'h0, q};
	endtask : mem_rd
	// Hang guard
	initial begin
		#200000;
		failures++;
		test_done();
	end
	// Main sequence
	initial begin
		{resetn, ce, aclr_in, aclr_out, we, re, bus_wr, bus_rd} = 8'h40;
		{waddr, raddr, din, bus_addr, bus_wdata} = '0;
		repeat (8) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		reg_rd(CFG_OFS, v);
		chk("cfg", 32'h1F80, v);
		reg_rd(STAT_OFS, v);
		chk("status", 32'h1, v);
		reg_rd(4'hC, v);
		chk("unmapped", 32'h0, v);
		mem_rd(5'd5, 0, v);
		chk("preload", 32'h2ABCD, v);
		mem_wr(5'd3, 18'h1A5A5);
		mem_wr(5'd31, 18'h25A5A);
		mem_rd(5'd3, 0, v);
		chk("q word3", 32'h1A5A5, v);
		mem_rd(5'd31, 0, v);
		chk("q word31", 32'h25A5A, v);
		aclr_out <= 1'b1;
		#1 chk("q clear", 32'h0, {14'h0, q});
		@(posedge clk);
		aclr_out <= 1'b0;
		reg_wr(CFG_OFS, 32'h1F40);
		mem_wr(5'd7, 18'h3FFFF);
		mem_rd(5'd7, 1, v);
		chk("q bypass", 32'h0FFFF, v);
		aclr_in <= 1'b1;
		@(posedge clk);
		aclr_in <= 1'b0;
		@(posedge clk);
		chk("q after input clear", 32'h0FFFF, {14'h0, q});
		reg_wr(CFG_OFS, 32'h1F83);
		mem_wr(5'd5, 18'h0);
		mem_rd(5'd5, 0, v);
		chk("q rom", 32'h2ABCD, v);
		reg_wr(CFG_OFS, 32'h1F82);
		for (int i = 0; i < 32; i++) mem_wr(5'(i), 18'(i + 256));
		#1 chk("full", 32'h1, {31'h0, fifo_full});
		reg_rd(STAT_OFS, v);
		chk("status full", 32'h82, v);
		mem_rd(5'd0, 0, v);
		chk("q fifo", 32'h100, v);
		reg_rd(STAT_OFS, v);
		chk("status 31", 32'h7C, v);
		test_done();
	end
endmodule : tb_small_dual_port_ram
